// ==== rtl/lutcr_pkg.sv ====
// Shared constants and helpers for the linked unit trigger and command relay
package lutcr_pkg;
	localparam int CLK_HZ        = 50_000_000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int DEF_BAUD      = 9600;
	localparam int DATA_BITS     = 8;
	localparam int STOP_BITS     = 1;
	localparam int FRAME_BITS    = 1 + DATA_BITS + STOP_BITS;
	localparam int CNT_W         = 16;
	localparam int RPY_LEN       = 8;
	localparam int TRIG_PULSE_NS = 1000;
	localparam int TRIG_PULSE_CYC =
		(TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] GLOBAL_ADDR = 8'h00;
	localparam logic [7:0] CH_CR       = 8'h0D;
	localparam logic [7:0] CH_COMMA    = 8'h2C;
	localparam logic [7:0] CH_ZERO     = 8'h30;
	localparam logic [7:0] CMD_BEGIN   = 8'h62;
	localparam logic [7:0] CMD_STATUS  = 8'h71;
	localparam logic [7:0] CMD_INPUT   = 8'h73;
	localparam logic [7:0] CMD_IDENT   = 8'h7A;
	localparam logic [7:0] DESC_BEGIN  = 8'h01;
	localparam logic [7:0] DESC_STATUS = 8'h00;
	localparam logic [7:0] DESC_INPUT  = 8'h14;
	localparam logic [7:0] DESC_VER    = 8'h00;
	localparam logic [7:0] DESC_TYPE   = 8'h01;
	localparam logic [7:0] DESC_CRC    = 8'h02;

	function automatic logic [CNT_W-1:0] bit_cycles(input int baud);
		return CNT_W'(CLK_HZ / baud);
	endfunction

	function automatic logic is_digit(input logic [7:0] c);
		return (c >= 8'h30) && (c <= 8'h39);
	endfunction

	function automatic logic is_letter(input logic [7:0] c);
		return ((c >= 8'h61) && (c <= 8'h7A)) || ((c >= 8'h41) && (c <= 8'h5A));
	endfunction

	// Wraps above 255; addresses and descriptors are small
	function automatic logic [7:0] dec_step(input logic [7:0] acc,
		input logic [7:0] c);
		return 8'((16'(acc) * 16'h000A) + 16'(c - CH_ZERO));
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction
endpackage

// ==== rtl/lutcr_link_if.sv ====
// Host serial lines and PLC logic lines between host end and unit end
`timescale 1ns/1ps
`default_nettype none
interface lutcr_link_if;
	logic host_txd;
	logic unit_txd;
	logic plc_trigger;
	logic chain_ready;
	modport host (output host_txd, output plc_trigger,
		input unit_txd, input chain_ready);
	modport unit (input host_txd, input plc_trigger,
		output unit_txd, output chain_ready);
endinterface
`default_nettype wire

// ==== rtl/lutcr_unit.sv ====
// Controller unit end: trigger chain, serial bridge and command parser
`timescale 1ns/1ps
`default_nettype none
module lutcr_unit #(
	parameter int          BAUD_RATE    = lutcr_pkg::DEF_BAUD,
	parameter logic [31:0] VERSION_TEXT = 32'h56312E30, // Arbitrary value
	parameter logic [31:0] TYPE_TEXT    = 32'h554E4954, // Arbitrary value
	parameter logic [15:0] FW_CHECKSUM  = 16'h5A3C      // Arbitrary value
) (
	input  wire logic       I_REF_CLK,
	input  wire logic       I_RESET,
	lutcr_link_if.unit      LINK,
	input  wire logic       I_GATE_ROLE,
	input  wire logic       I_BRIDGE_ROLE,
	input  wire logic       I_LAST_UNIT,
	input  wire logic [7:0] I_UNIT_ADDRESS,
	input  wire logic       I_OWN_READY,
	input  wire logic       I_CONTACT_IN_ONE,
	input  wire logic       I_CONTACT_IN_TWO,
	input  wire logic       I_RS485_RXD,
	output logic            O_LINK_OUT_ONE,
	output logic            O_LINK_OUT_TWO,
	output logic            O_RS485_TXD,
	output logic            O_RS485_DE,
	output logic            O_START
);
	import lutcr_pkg::*;

	localparam logic [CNT_W-1:0] BIT_CYC  = bit_cycles(BAUD_RATE);
	localparam logic [CNT_W-1:0] HALF_CYC = BIT_CYC >> 1;

	typedef enum logic [4:0] {
		P_ADDR  = 5'b00001,
		P_DESC  = 5'b00010,
		P_VALUE = 5'b00100,
		P_SKIP  = 5'b01000,
		P_REPLY = 5'b10000
	} lutcr_pst_e;

	logic                          ready_all;
	logic                          trig_in;
	logic                          fwd;
	logic                          start_nxt;
	logic                          fwd_r;
	logic                          ready_r;
	logic                          start_r;
	logic                          rx_line;
	logic                          rx_busy_r,  rx_busy_nxt;
	logic [CNT_W-1:0]              rx_cnt_r,   rx_cnt_nxt;
	logic [3:0]                    rx_bit_r,   rx_bit_nxt;
	logic [7:0]                    rx_sh_r,    rx_sh_nxt;
	logic                          rx_vld_r,   rx_vld_nxt;
	lutcr_pst_e                    pst_r,      pst_nxt;
	logic [7:0]                    addr_r,     addr_nxt;
	logic [7:0]                    cmd_r,      cmd_nxt;
	logic [7:0]                    desc_r,     desc_nxt;
	logic [RPY_LEN-1:0][7:0]       rpy_r,      rpy_nxt;
	logic [3:0]                    len_r,      len_nxt;
	logic [3:0]                    idx_r,      idx_nxt;
	logic                          begin_r,    begin_nxt;
	logic                          exec;
	logic                          own;
	logic                          glb;
	logic [31:0]                   txt;
	logic                          txt_ok;
	logic                          tx_load;
	logic [7:0]                    tx_data;
	logic                          tx_busy_r,  tx_busy_nxt;
	logic [CNT_W-1:0]              tx_cnt_r,   tx_cnt_nxt;
	logic [3:0]                    tx_bit_r,   tx_bit_nxt;
	logic [FRAME_BITS-1:0]         tx_sh_r,    tx_sh_nxt;
	logic                          own_line;
	logic                          rs_txd_r,   rs_txd_nxt;
	logic                          rs_de_r,    rs_de_nxt;
	logic                          h_txd_r,    h_txd_nxt;

	// Trigger and ready chain
	always_comb
	begin
		ready_all = I_OWN_READY & (I_LAST_UNIT | I_CONTACT_IN_TWO);
		trig_in   = I_CONTACT_IN_ONE | LINK.plc_trigger;
		fwd       = trig_in & (~I_GATE_ROLE | ready_all);
		start_nxt = (fwd & ~fwd_r & I_OWN_READY) | begin_r;
	end

	always_ff @(posedge I_REF_CLK)
		if (I_RESET)
		begin
			fwd_r   <= 1'b0;
			ready_r <= 1'b0;
			start_r <= 1'b0;
		end
		else
		begin
			fwd_r   <= fwd;
			ready_r <= ready_all;
			start_r <= start_nxt;
		end

	// Bridge listens on the host line, others on the multidrop line
	assign rx_line = I_BRIDGE_ROLE ? LINK.host_txd : I_RS485_RXD;

	// Receiver, centre sampled 8N1
	always_comb
	begin
		rx_busy_nxt = rx_busy_r;
		rx_cnt_nxt  = rx_cnt_r;
		rx_bit_nxt  = rx_bit_r;
		rx_sh_nxt   = rx_sh_r;
		rx_vld_nxt  = 1'b0;
		if (!rx_busy_r)
		begin
			if (!rx_line)
			begin
				rx_busy_nxt = 1'b1;
				rx_cnt_nxt  = HALF_CYC;
				rx_bit_nxt  = 4'h0;
			end
		end
		else if (rx_cnt_r != '0)
			rx_cnt_nxt = rx_cnt_r - 1'b1;
		else
		begin
			rx_cnt_nxt = BIT_CYC - 1'b1;
			rx_bit_nxt = rx_bit_r + 4'h1;
			if ((rx_bit_r == 4'h0) && rx_line)
				rx_busy_nxt = 1'b0;
			else if (rx_bit_r == 4'(FRAME_BITS - 1))
			begin
				rx_busy_nxt = 1'b0;
				rx_vld_nxt  = rx_line;
			end
			else if (rx_bit_r != 4'h0)
				rx_sh_nxt = {rx_line, rx_sh_r[7:1]};
		end
	end

	always_ff @(posedge I_REF_CLK)
		if (I_RESET)
		begin
			rx_busy_r <= 1'b0;
			rx_cnt_r  <= '0;
			rx_bit_r  <= 4'h0;
			rx_sh_r   <= 8'h00;
			rx_vld_r  <= 1'b0;
		end
		else
		begin
			rx_busy_r <= rx_busy_nxt;
			rx_cnt_r  <= rx_cnt_nxt;
			rx_bit_r  <= rx_bit_nxt;
			rx_sh_r   <= rx_sh_nxt;
			rx_vld_r  <= rx_vld_nxt;
		end

	// Command parser; bytes arriving while a reply goes out, except during its last byte, are dropped
	always_comb
	begin
		pst_nxt   = pst_r;
		addr_nxt  = addr_r;
		cmd_nxt   = cmd_r;
		desc_nxt  = desc_r;
		rpy_nxt   = rpy_r;
		len_nxt   = len_r;
		idx_nxt   = idx_r;
		begin_nxt = 1'b0;
		tx_load   = 1'b0;
		tx_data   = rpy_r[idx_r[2:0]];
		txt       = 32'h00000000;
		txt_ok    = 1'b0;
		exec      = 1'b0;
		own = (addr_r == I_UNIT_ADDRESS) && (addr_r != GLOBAL_ADDR);
		glb = (addr_r == GLOBAL_ADDR);
		unique case (pst_r)
			P_ADDR:
				if (rx_vld_r)
				begin
					if (is_digit(rx_sh_r))
						addr_nxt = dec_step(addr_r, rx_sh_r);
					else if (is_letter(rx_sh_r))
					begin
						cmd_nxt  = rx_sh_r;
						desc_nxt = 8'h00;
						pst_nxt  = P_DESC;
					end
					else if (rx_sh_r == CH_CR)
						addr_nxt = 8'h00;
					else
						pst_nxt = P_SKIP;
				end
			P_DESC, P_VALUE:
				if (rx_vld_r)
				begin
					if (rx_sh_r == CH_CR)
						exec = 1'b1;
					else if (is_letter(rx_sh_r))
						pst_nxt = P_SKIP;
					else if (rx_sh_r == CH_COMMA)
						pst_nxt = P_VALUE;
					else if (is_digit(rx_sh_r) && (pst_r == P_DESC))
						desc_nxt = dec_step(desc_r, rx_sh_r);
					else if (pst_r == P_DESC)
						pst_nxt = P_SKIP;
				end
			P_SKIP:
				if (rx_vld_r && (rx_sh_r == CH_CR))
				begin
					pst_nxt  = P_ADDR;
					addr_nxt = 8'h00;
				end
			P_REPLY:
				if (!tx_busy_r)
				begin
					tx_load = 1'b1;
					idx_nxt = idx_r + 4'h1;
					if (idx_nxt == len_r)
						pst_nxt = P_ADDR;
				end
		endcase
		if (exec)
		begin
			pst_nxt  = P_ADDR;
			addr_nxt = 8'h00;
			idx_nxt  = 4'h0;
			// Neither match: nothing happens and nothing is sent
			if ((own || glb) && (cmd_r == CMD_BEGIN) && (desc_r == DESC_BEGIN))
				begin_nxt = 1'b1;
			if (own)
			begin
				rpy_nxt[0] = cmd_r;
				rpy_nxt[1] = CH_COMMA;
				rpy_nxt[3] = CH_CR;
				len_nxt    = 4'h4;
				if ((cmd_r == CMD_STATUS) && (desc_r == DESC_STATUS))
				begin
					rpy_nxt[2] = CH_ZERO | {7'h00, I_OWN_READY};
					pst_nxt    = P_REPLY;
				end
				else if ((cmd_r == CMD_INPUT) && (desc_r == DESC_INPUT))
				begin
					rpy_nxt[2] = CH_ZERO | {7'h00, ready_all};
					pst_nxt    = P_REPLY;
				end
				else if (cmd_r == CMD_IDENT)
				begin
					txt_ok = 1'b1;
					if (desc_r == DESC_VER)
						txt = VERSION_TEXT;
					else if (desc_r == DESC_TYPE)
						txt = TYPE_TEXT;
					else if (desc_r == DESC_CRC)
						txt = {hex_char(FW_CHECKSUM[15:12]),
							hex_char(FW_CHECKSUM[11:8]),
							hex_char(FW_CHECKSUM[7:4]),
							hex_char(FW_CHECKSUM[3:0])};
					else
						txt_ok = 1'b0;
				end
				if (txt_ok)
				begin
					rpy_nxt[2] = txt[31:24];
					rpy_nxt[3] = txt[23:16];
					rpy_nxt[4] = txt[15:8];
					rpy_nxt[5] = txt[7:0];
					rpy_nxt[6] = CH_CR;
					len_nxt    = 4'h7;
					pst_nxt    = P_REPLY;
				end
			end
		end
	end

	always_ff @(posedge I_REF_CLK)
		if (I_RESET)
		begin
			pst_r   <= P_ADDR;
			addr_r  <= 8'h00;
			cmd_r   <= 8'h00;
			desc_r  <= 8'h00;
			rpy_r   <= '0;
			len_r   <= 4'h0;
			idx_r   <= 4'h0;
			begin_r <= 1'b0;
		end
		else
		begin
			pst_r   <= pst_nxt;
			addr_r  <= addr_nxt;
			cmd_r   <= cmd_nxt;
			desc_r  <= desc_nxt;
			rpy_r   <= rpy_nxt;
			len_r   <= len_nxt;
			idx_r   <= idx_nxt;
			begin_r <= begin_nxt;
		end

	// Reply transmitter and line routing
	always_comb
	begin
		tx_busy_nxt = tx_busy_r;
		tx_cnt_nxt  = tx_cnt_r;
		tx_bit_nxt  = tx_bit_r;
		tx_sh_nxt   = tx_sh_r;
		if (tx_load)
		begin
			tx_busy_nxt = 1'b1;
			tx_cnt_nxt  = BIT_CYC - 1'b1;
			tx_bit_nxt  = 4'h0;
			tx_sh_nxt   = {1'b1, tx_data, 1'b0};
		end
		else if (tx_busy_r)
		begin
			if (tx_cnt_r != '0)
				tx_cnt_nxt = tx_cnt_r - 1'b1;
			else
			begin
				tx_cnt_nxt = BIT_CYC - 1'b1;
				tx_sh_nxt  = {1'b1, tx_sh_r[FRAME_BITS-1:1]};
				tx_bit_nxt = tx_bit_r + 4'h1;
				if (tx_bit_r == 4'(FRAME_BITS - 1))
					tx_busy_nxt = 1'b0;
			end
		end
		own_line = tx_busy_nxt ? tx_sh_nxt[0] : 1'b1;
		// Bit-level relay: no buffering, no added latency beyond one flop
		if (I_BRIDGE_ROLE)
		begin
			rs_txd_nxt = LINK.host_txd;
			rs_de_nxt  = 1'b1;
			h_txd_nxt  = own_line & I_RS485_RXD;
		end
		else
		begin
			rs_txd_nxt = own_line;
			rs_de_nxt  = tx_busy_nxt;
			h_txd_nxt  = 1'b1;
		end
	end

	always_ff @(posedge I_REF_CLK)
		if (I_RESET)
		begin
			tx_busy_r <= 1'b0;
			tx_cnt_r  <= '0;
			tx_bit_r  <= 4'h0;
			tx_sh_r   <= '1;
			rs_txd_r  <= 1'b1;
			rs_de_r   <= 1'b0;
			h_txd_r   <= 1'b1;
		end
		else
		begin
			tx_busy_r <= tx_busy_nxt;
			tx_cnt_r  <= tx_cnt_nxt;
			tx_bit_r  <= tx_bit_nxt;
			tx_sh_r   <= tx_sh_nxt;
			rs_txd_r  <= rs_txd_nxt;
			rs_de_r   <= rs_de_nxt;
			h_txd_r   <= h_txd_nxt;
		end

	assign O_LINK_OUT_ONE   = fwd_r;
	assign O_LINK_OUT_TWO   = ready_r;
	assign O_START          = start_r;
	assign O_RS485_TXD      = rs_txd_r;
	assign O_RS485_DE       = rs_de_r;
	assign LINK.chain_ready = ready_r;
	assign LINK.unit_txd    = h_txd_r;
endmodule // lutcr_unit
`default_nettype wire

// ==== rtl/lutcr_host.sv ====
// Host end: command byte sender, reply receiver and PLC trigger output
`timescale 1ns/1ps
`default_nettype none
module lutcr_host #(
	parameter int BAUD_RATE = lutcr_pkg::DEF_BAUD,
	parameter int TRIG_CYC  = lutcr_pkg::TRIG_PULSE_CYC
) (
	input  wire logic       I_REF_CLK,
	input  wire logic       I_RESET,
	lutcr_link_if.host      LINK,
	input  wire logic [7:0] I_CMD_DATA,
	input  wire logic       I_CMD_VALID,
	output logic            O_CMD_READY,
	output logic [7:0]      O_RPY_DATA,
	output logic            O_RPY_VALID,
	input  wire logic       I_TRIGGER_REQ,
	output logic            O_TRIGGER_REFUSED
);
	import lutcr_pkg::*;

	localparam logic [CNT_W-1:0] BIT_CYC  = bit_cycles(BAUD_RATE);
	localparam logic [CNT_W-1:0] HALF_CYC = BIT_CYC >> 1;
	localparam logic [CNT_W-1:0] TRG_LEN  = CNT_W'(TRIG_CYC);

	logic                  tx_busy_r, tx_busy_nxt;
	logic [CNT_W-1:0]      tx_cnt_r,  tx_cnt_nxt;
	logic [3:0]            tx_bit_r,  tx_bit_nxt;
	logic [FRAME_BITS-1:0] tx_sh_r,   tx_sh_nxt;
	logic                  txd_r;
	logic                  rdy_r;
	logic                  rx_busy_r, rx_busy_nxt;
	logic [CNT_W-1:0]      rx_cnt_r,  rx_cnt_nxt;
	logic [3:0]            rx_bit_r,  rx_bit_nxt;
	logic [7:0]            rx_sh_r,   rx_sh_nxt;
	logic                  rx_vld_r,  rx_vld_nxt;
	logic [CNT_W-1:0]      trg_cnt_r, trg_cnt_nxt;
	logic                  trg_r;
	logic                  refused_r, refused_nxt;

	// Command transmitter, 8N1
	always_comb
	begin
		tx_busy_nxt = tx_busy_r;
		tx_cnt_nxt  = tx_cnt_r;
		tx_bit_nxt  = tx_bit_r;
		tx_sh_nxt   = tx_sh_r;
		if (I_CMD_VALID && rdy_r)
		begin
			tx_busy_nxt = 1'b1;
			tx_cnt_nxt  = BIT_CYC - 1'b1;
			tx_bit_nxt  = 4'h0;
			tx_sh_nxt   = {1'b1, I_CMD_DATA, 1'b0};
		end
		else if (tx_busy_r)
		begin
			if (tx_cnt_r != '0)
				tx_cnt_nxt = tx_cnt_r - 1'b1;
			else
			begin
				tx_cnt_nxt = BIT_CYC - 1'b1;
				tx_sh_nxt  = {1'b1, tx_sh_r[FRAME_BITS-1:1]};
				tx_bit_nxt = tx_bit_r + 4'h1;
				if (tx_bit_r == 4'(FRAME_BITS - 1))
					tx_busy_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge I_REF_CLK)
		if (I_RESET)
		begin
			tx_busy_r <= 1'b0;
			tx_cnt_r  <= '0;
			tx_bit_r  <= 4'h0;
			tx_sh_r   <= '1;
			txd_r     <= 1'b1;
			rdy_r     <= 1'b0;
		end
		else
		begin
			tx_busy_r <= tx_busy_nxt;
			tx_cnt_r  <= tx_cnt_nxt;
			tx_bit_r  <= tx_bit_nxt;
			tx_sh_r   <= tx_sh_nxt;
			txd_r     <= tx_busy_nxt ? tx_sh_nxt[0] : 1'b1;
			rdy_r     <= ~tx_busy_nxt;
		end

	// Reply receiver, centre sampled
	always_comb
	begin
		rx_busy_nxt = rx_busy_r;
		rx_cnt_nxt  = rx_cnt_r;
		rx_bit_nxt  = rx_bit_r;
		rx_sh_nxt   = rx_sh_r;
		rx_vld_nxt  = 1'b0;
		if (!rx_busy_r)
		begin
			if (!LINK.unit_txd)
			begin
				rx_busy_nxt = 1'b1;
				rx_cnt_nxt  = HALF_CYC;
				rx_bit_nxt  = 4'h0;
			end
		end
		else if (rx_cnt_r != '0)
			rx_cnt_nxt = rx_cnt_r - 1'b1;
		else
		begin
			rx_cnt_nxt = BIT_CYC - 1'b1;
			rx_bit_nxt = rx_bit_r + 4'h1;
			if ((rx_bit_r == 4'h0) && LINK.unit_txd)
				rx_busy_nxt = 1'b0;
			else if (rx_bit_r == 4'(FRAME_BITS - 1))
			begin
				rx_busy_nxt = 1'b0;
				rx_vld_nxt  = LINK.unit_txd;
			end
			else if (rx_bit_r != 4'h0)
				rx_sh_nxt = {LINK.unit_txd, rx_sh_r[7:1]};
		end
	end

	always_ff @(posedge I_REF_CLK)
		if (I_RESET)
		begin
			rx_busy_r <= 1'b0;
			rx_cnt_r  <= '0;
			rx_bit_r  <= 4'h0;
			rx_sh_r   <= 8'h00;
			rx_vld_r  <= 1'b0;
		end
		else
		begin
			rx_busy_r <= rx_busy_nxt;
			rx_cnt_r  <= rx_cnt_nxt;
			rx_bit_r  <= rx_bit_nxt;
			rx_sh_r   <= rx_sh_nxt;
			rx_vld_r  <= rx_vld_nxt;
		end

	// Trigger pulse; a request while one is running is dropped
	always_comb
	begin
		trg_cnt_nxt = trg_cnt_r;
		refused_nxt = 1'b0;
		if (trg_cnt_r != '0)
			trg_cnt_nxt = trg_cnt_r - 1'b1;
		else if (I_TRIGGER_REQ)
		begin
			if (LINK.chain_ready)
				trg_cnt_nxt = TRG_LEN;
			else
				refused_nxt = 1'b1;
		end
	end

	always_ff @(posedge I_REF_CLK)
		if (I_RESET)
		begin
			trg_cnt_r <= '0;
			trg_r     <= 1'b0;
			refused_r <= 1'b0;
		end
		else
		begin
			trg_cnt_r <= trg_cnt_nxt;
			trg_r     <= (trg_cnt_nxt != '0);
			refused_r <= refused_nxt;
		end

	assign LINK.host_txd     = txd_r;
	assign LINK.plc_trigger  = trg_r;
	assign O_CMD_READY       = rdy_r;
	assign O_RPY_DATA        = rx_sh_r;
	assign O_RPY_VALID       = rx_vld_r;
	assign O_TRIGGER_REFUSED = refused_r;
endmodule // lutcr_host
`default_nettype wire

// ==== verif/lutcr_link_chk.sv ====
// Concurrent checks on the lines between host end and unit end
`timescale 1ns/1ps
`default_nettype none
module lutcr_link_chk
	import lutcr_pkg::*;
#(
	parameter int BIT_CYC = 5208
) (
	input  wire logic I_REF_CLK,
	input  wire logic I_RESET,
	input  wire logic host_txd,
	input  wire logic unit_txd,
	input  wire logic plc_trigger,
	input  wire logic chain_ready
);
	import lutcr_pkg::*;

	// Run lengths of low and high levels; high runs saturate so idle never wraps
	logic [15:0] h_lo_r;
	logic [15:0] h_lo_nxt;
	logic [15:0] h_hi_r;
	logic [15:0] h_hi_nxt;
	logic [15:0] u_lo_r;
	logic [15:0] u_lo_nxt;
	logic [15:0] u_hi_r;
	logic [15:0] u_hi_nxt;

	always_comb
	begin
		h_lo_nxt = host_txd ? 16'h0000 : h_lo_r + 16'h0001;
		u_lo_nxt = unit_txd ? 16'h0000 : u_lo_r + 16'h0001;
		h_hi_nxt = !host_txd ? 16'h0000 : h_hi_r + {15'h0000, ~&h_hi_r};
		u_hi_nxt = !unit_txd ? 16'h0000 : u_hi_r + {15'h0000, ~&u_hi_r};
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			h_lo_r <= 16'h0000;
			u_lo_r <= 16'h0000;
			h_hi_r <= 16'hFFFF;
			u_hi_r <= 16'hFFFF;
		end
		else
		begin
			h_lo_r <= h_lo_nxt;
			u_lo_r <= u_lo_nxt;
			h_hi_r <= h_hi_nxt;
			u_hi_r <= u_hi_nxt;
		end
	end

	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_RESET);

	a_reset_idle_lines: assert property ($fell(I_RESET) |->
		host_txd && unit_txd && !plc_trigger && !chain_ready)
		else $error("link lines not idle after reset");
	a_host_low_run: assert property ($rose(host_txd) |->
		(h_lo_r % BIT_CYC == 0) && (h_lo_r <= 9 * BIT_CYC))
		else $error("host line low run not whole bits");
	a_unit_low_run: assert property ($rose(unit_txd) |->
		(u_lo_r % BIT_CYC == 0) && (u_lo_r <= 9 * BIT_CYC))
		else $error("unit line low run not whole bits");
	a_host_high_run: assert property ($fell(host_txd) |->
		h_hi_r >= BIT_CYC)
		else $error("host line high run shorter than a bit");
	a_unit_high_run: assert property ($fell(unit_txd) |->
		u_hi_r >= BIT_CYC)
		else $error("unit line high run shorter than a bit");
	a_trig_needs_ready: assert property ($rose(plc_trigger) |->
		$past(chain_ready))
		else $error("trigger raised while chain not ready");
	// Pulse stands exactly the bench trigger length of four cycles
	a_trig_pulse_len: assert property ($rose(plc_trigger) |->
		plc_trigger[*4] ##1 !plc_trigger)
		else $error("trigger pulse length wrong");
	a_reply_after_cmd: assert property ($fell(unit_txd) |->
		host_txd)
		else $error("reply started while command still arriving");

	c_trigger: cover property ($rose(plc_trigger));
	c_reply: cover property ($fell(unit_txd));
	c_command: cover property ($fell(host_txd));
endmodule // lutcr_link_chk
`default_nettype wire

// ==== verif/linked_unit_trigger_and_command_relay_tb_top.sv ====
// Bench joining host end and unit end over the link interface
`timescale 1ns/1ps
`default_nettype none
module linked_unit_trigger_and_command_relay_tb_top;
	import lutcr_pkg::*;
	// Fast baud keeps frames short
	localparam int BAUD = 1_000_000;
	localparam int B = CLK_HZ / BAUD;
	localparam int LIMIT = 90000;
	localparam logic [31:0] VER = 32'h52322E37; // Arbitrary value
	localparam logic [31:0] TYP = 32'h4354524C; // Arbitrary value
	localparam logic [15:0] CSUM = 16'hB7E1;    // Arbitrary value

	logic       clk, rst, gate, bridge, last, own, c1, c2, rxd, trig_req;
	logic       cmd_valid, cmd_ready, rpy_valid, refused, hd_prev;
	logic       lo1, lo2, txd485, de485, start;
	logic       relay_on = 1'b0;
	logic [7:0] addr, cmd_data, rpy_data;
	logic [7:0] rx_q[$];
	int         n_fail = 0;
	int         checks_done = 0;
	int         n_start = 0;
	int         n_refused = 0;
	int         cyc = 0;
	string      cs;

	lutcr_link_if link_bus();

	lutcr_host #(.BAUD_RATE(BAUD), .TRIG_CYC(4)) u_lutcr_host (
		.I_REF_CLK(clk), .I_RESET(rst), .LINK(link_bus),
		.I_CMD_DATA(cmd_data), .I_CMD_VALID(cmd_valid),
		.O_CMD_READY(cmd_ready), .O_RPY_DATA(rpy_data),
		.O_RPY_VALID(rpy_valid), .I_TRIGGER_REQ(trig_req),
		.O_TRIGGER_REFUSED(refused));

	lutcr_unit #(.BAUD_RATE(BAUD), .VERSION_TEXT(VER), .TYPE_TEXT(TYP),
		.FW_CHECKSUM(CSUM)) u_lutcr_unit (
		.I_REF_CLK(clk), .I_RESET(rst), .LINK(link_bus),
		.I_GATE_ROLE(gate), .I_BRIDGE_ROLE(bridge), .I_LAST_UNIT(last),
		.I_UNIT_ADDRESS(addr), .I_OWN_READY(own),
		.I_CONTACT_IN_ONE(c1), .I_CONTACT_IN_TWO(c2), .I_RS485_RXD(rxd),
		.O_LINK_OUT_ONE(lo1), .O_LINK_OUT_TWO(lo2), .O_RS485_TXD(txd485),
		.O_RS485_DE(de485), .O_START(start));

	lutcr_link_chk #(.BIT_CYC(B)) u_lutcr_link_chk (
		.I_REF_CLK(clk), .I_RESET(rst), .host_txd(link_bus.host_txd),
		.unit_txd(link_bus.unit_txd), .plc_trigger(link_bus.plc_trigger),
		.chain_ready(link_bus.chain_ready));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Pulses counted off the edge; the relay copy lags the host line one cycle
	always @(negedge clk)
	begin
		cyc++;
		if (start === 1'b1)
			n_start++;
		if (refused === 1'b1)
			n_refused++;
		if (rpy_valid === 1'b1)
			rx_q.push_back(rpy_data);
		// Relay judged only after reset and role stood a whole cycle
		if (rst === 1'b0 && bridge === 1'b1 && relay_on)
		begin
			check("relay_txd", {31'h0, txd485}, {31'h0, hd_prev});
			check("relay_de", {31'h0, de485}, 32'h00000001);
		end
		relay_on = (rst === 1'b0) && (bridge === 1'b1);
		hd_prev = link_bus.host_txd;
		if (cyc == LIMIT)
		begin
			n_fail++;
			finish_test();
		end
	end

	// Sends one byte and samples its frame mid-bit on the wire
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] bits;
		int i;
		#1;
		for (i = 0; cmd_ready !== 1'b1 && i < 30 * B; i++)
			@(posedge clk);
		#1;
		cmd_data = b;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		repeat (B / 2) @(posedge clk);
		for (i = 0; i < 10; i++)
		begin
			#2;
			bits[i] = link_bus.host_txd;
			repeat (B) @(posedge clk);
		end
		check("host_frame", {22'h0, bits}, {22'h0, 1'b1, b, 1'b0});
	endtask

	task automatic run_cmd(input string s, input string rep, input int starts);
		int i;
		int n0;
		string exp;
		exp = (rep.len() == 0) ? "" : {rep, "\015"};
		n0 = n_start;
		rx_q.delete();
		for (i = 0; i < s.len(); i++)
			send_byte(s[i]);
		send_byte(CH_CR);
		for (i = 0; i < 60 * B && (exp.len() == 0 || rx_q.size() < exp.len()); i++)
			@(posedge clk);
		repeat (12 * B) @(posedge clk);
		check("reply_len", rx_q.size(), exp.len());
		for (i = 0; i < exp.len(); i++)
			check("reply_byte", {24'h0, rx_q[i]}, {24'h0, exp[i]});
		check("start_count", n_start - n0, starts);
	endtask

	// Every gate role, last unit and readiness combination with one contact trigger each
	task automatic t_chain();
		int k;
		int n0;
		logic rdy;
		logic fwd;
		for (k = 0; k < 16; k++)
		begin
			{gate, last, own, c2} = 4'(k);
			rdy = own & (last | c2);
			fwd = !gate | rdy;
			repeat (4) @(posedge clk);
			#1;
			n0 = n_start;
			c1 = 1'b1;
			repeat (4) @(posedge clk);
			#1;
			check("link_out_one", {31'h0, lo1}, {31'h0, fwd});
			check("link_out_two", {31'h0, lo2}, {31'h0, rdy});
			check("chain_ready", {31'h0, link_bus.chain_ready}, {31'h0, rdy});
			check("chain_start", n_start - n0, {31'h0, fwd & own});
			c1 = 1'b0;
		end
	endtask

	// Logic input trigger taken when ready, refused when not
	task automatic t_plc();
		int j;
		int n0;
		int r0;
		{gate, last, own, c2} = 4'b1110;
		n0 = n_start;
		r0 = n_refused;
		for (j = 0; j < 2; j++)
		begin
			own = (j == 0);
			repeat (4) @(posedge clk);
			#1;
			trig_req = 1'b1;
			@(posedge clk);
			#1;
			trig_req = 1'b0;
			repeat (12) @(posedge clk);
			#1;
		end
		check("plc_start", n_start - n0, 32'h00000001);
		check("plc_refused", n_refused - r0, 32'h00000001);
	endtask

	// Non-bridge unit: command on the bus line, reply on the bus driver
	task automatic t_multidrop();
		string s;
		string r;
		logic [9:0] f;
		int i;
		int j;
		int w;
		s = "2q0\015";
		r = "q,1\015";
		#1;
		bridge = 1'b0;
		for (i = 0; i < 4; i++)
		begin
			f = {1'b1, s[i], 1'b0};
			for (j = 0; j < 10; j++)
			begin
				rxd = f[j];
				if (i < 3 || j < 9)
				begin
					repeat (B) @(posedge clk);
					#1;
				end
			end
		end
		for (i = 0; i < 4; i++)
		begin
			for (w = 0; w < 20 * B && txd485 !== 1'b0; w++)
			begin
				@(posedge clk);
				#1;
			end
			repeat (B / 2) @(posedge clk);
			for (j = 0; j < 10; j++)
			begin
				#2;
				f[j] = txd485;
				check("bus_de", {31'h0, de485}, 32'h00000001);
				if (j < 9)
					repeat (B) @(posedge clk);
			end
			check("bus_frame", {22'h0, f}, {22'h0, 1'b1, r[i], 1'b0});
		end
		repeat (B) @(posedge clk);
		#1;
		check("bus_de_idle", {31'h0, de485}, 32'h00000000);
		bridge = 1'b1;
	endtask

	initial
	begin
		{rst, gate, bridge, last, own, c1, c2} = 7'h71;
		{rxd, trig_req, cmd_valid} = 3'h4;
		addr = 8'h02;
		cmd_data = 8'h00;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		t_chain();
		t_plc();
		{gate, last, own, c2} = 4'b0110;
		run_cmd("2q0", "q,1", 0);
		run_cmd("0q0", "", 0);
		run_cmd("5q0", "", 0);
		run_cmd("2qq0", "", 0);
		run_cmd("0b1", "", 1);
		run_cmd("2b1", "", 1);
		run_cmd("5b1", "", 0);
		run_cmd("2s20", "s,1", 0);
		{last, c2} = 2'b00;
		run_cmd("2s20", "s,0", 0);
		run_cmd("2z0", $sformatf("z,%s", VER), 0);
		run_cmd("2z1", $sformatf("z,%s", TYP), 0);
		cs = $sformatf("%h", CSUM);
		run_cmd("2z2", {"z,", cs.toupper()}, 0);
		t_multidrop();
		finish_test();
	end
endmodule // linked_unit_trigger_and_command_relay_tb_top
`default_nettype wire
